// File: src/pgs_clk_div.sv
// one programmable divider: turns reference ticks into divided clock enables
// assumes refTick is a one-cycle pulse on clk_sys; load arrives only while paused
`timescale 1ns/1ps
`default_nettype none
module pgs_clk_div
  import pgs_pkg::*;
#(
  parameter logic [RATIO_W-1:0] RST_RATIO = 5'h00
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               ce,
  input  wire logic               refTick,
  input  wire logic               pause,
  input  wire logic               load,
  input  wire logic [RATIO_W-1:0] newRatio,
  output logic      [RATIO_W-1:0] curRatio,
  output logic                    divTick
);

  logic [RATIO_W-1:0] cnt;
  logic [RATIO_W-1:0] next_cnt;
  logic [RATIO_W-1:0] next_curRatio;
  logic               next_divTick;

  always_comb begin
    next_cnt      = cnt;
    next_curRatio = curRatio;
    next_divTick  = 1'b0;
    if (load) begin
      // restart from a period boundary so the new rate starts without a runt pulse
      next_curRatio = newRatio;
      next_cnt      = '0;
    end else if (pause) begin
      next_cnt = '0;
    end else if (refTick) begin
      if (cnt == curRatio) begin
        next_cnt     = '0;
        next_divTick = 1'b1;
      end else begin
        next_cnt = cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt      <= '0;
      curRatio <= RST_RATIO;
      divTick  <= 1'b0;
    end else if (ce) begin
      cnt      <= next_cnt;
      curRatio <= next_curRatio;
      divTick  <= next_divTick;
    end
  end

  a_pause_silent: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && pause) |=> !divTick)
    else $error("divided clock ticked while paused");

endmodule // pgs_clk_div
`default_nettype wire

// File: src/pgs_go_timer.sv
// go operation timer: counts reference ticks up to the computed wait
// assumes start is taken only while idle and applyAt lies below nCycles
`timescale 1ns/1ps
`default_nettype none
module pgs_go_timer
  import pgs_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic              refTick,
  input  wire logic [WAIT_W-1:0] nCycles,
  input  wire logic [WAIT_W-1:0] applyAt,
  output logic                   busy,
  output logic                   apply,
  output logic                   done
);

  logic [WAIT_W-1:0] cnt;
  logic [WAIT_W-1:0] lenN;
  logic [WAIT_W-1:0] lenA;
  logic [WAIT_W-1:0] next_cnt;
  logic [WAIT_W-1:0] next_lenN;
  logic [WAIT_W-1:0] next_lenA;
  logic              next_busy;
  logic              next_apply;
  logic              next_done;

  always_comb begin
    next_cnt   = cnt;
    next_lenN  = lenN;
    next_lenA  = lenA;
    next_busy  = busy;
    next_apply = 1'b0;
    next_done  = 1'b0;
    if (start && !busy) begin
      next_busy = 1'b1;
      next_cnt  = '0;
      next_lenN = nCycles;
      next_lenA = applyAt;
    end else if (busy && refTick) begin
      next_cnt = cnt + 12'h001;
      if (next_cnt == lenA) begin
        next_apply = 1'b1;
      end
      if (next_cnt == lenN) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt   <= '0;
      lenN  <= '0;
      lenA  <= '0;
      busy  <= 1'b0;
      apply <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      cnt   <= next_cnt;
      lenN  <= next_lenN;
      lenA  <= next_lenA;
      busy  <= next_busy;
      apply <= next_apply;
      done  <= next_done;
    end
  end

  a_wait_bounded: assert property (@(posedge clk_sys) disable iff (!nrst)
    busy |-> (cnt <= lenN))
    else $error("go timer ran past its wait");

  a_done_at_n: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(done) |-> (cnt == lenN) && !busy)
    else $error("go finished before the computed wait");

endmodule // pgs_go_timer
`default_nettype wire

// File: src/pgs_pkg.sv
// package of the divider go sequencer: register map, field layout, reset values and wait arithmetic
// assumes a 32-bit word register port with byte addresses on word boundaries
package pgs_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          RATIO_W       = 5;
  localparam int          WAIT_W        = 12;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STAT      = 8'h04;
  localparam logic [7:0]  OFS_CMD       = 8'h08;
  localparam logic [7:0]  OFS_DIV4      = 8'h0C;
  localparam logic [7:0]  OFS_DIV5      = 8'h10;
  localparam logic [7:0]  OFS_DIV21     = 8'h14;
  localparam logic [7:0]  OFS_DCHG      = 8'h18;
  localparam logic [7:0]  OFS_ISTAT     = 8'h1C;
  localparam logic [7:0]  OFS_IMASK     = 8'h20;

  localparam int          BIT_LOCKED    = 0;
  localparam int          BIT_GO1       = 0;
  localparam int          BIT_GO2       = 1;
  localparam int          BIT_BUSY1     = 8;
  localparam int          BIT_BUSY2     = 9;
  localparam int          BIT_CHG4      = 0;
  localparam int          BIT_CHG5      = 1;
  localparam int          BIT_CHG21     = 2;

  localparam logic             RST_LOCKED = 1'b0;
  localparam logic [RATIO_W-1:0] RST_RATIO4  = 5'h03;
  localparam logic [RATIO_W-1:0] RST_RATIO5  = 5'h03;
  localparam logic [RATIO_W-1:0] RST_RATIO21 = 5'h01;
  localparam logic [1:0]  RST_IMASK     = 2'h0;

  localparam logic [WAIT_W-1:0] GO_LCM_MULT = 12'h002;
  localparam logic [WAIT_W-1:0] GO_OVERHEAD = 12'h032;

  // least common multiple of two divide values (1..32), search over multiples of a
  function automatic logic [10:0] pgs_lcm(input logic [5:0] a, input logic [5:0] b);
    logic [10:0] r;
    r = 11'(a) * 11'(b);
    for (int k = 32; k >= 1; k--) begin
      if (((11'(a) * 11'(k)) % 11'(b)) == 11'h000) begin
        r = 11'(a) * 11'(k);
      end
    end
    return r;
  endfunction

  // divide value of a ratio field
  function automatic logic [5:0] pgs_divval(input logic [RATIO_W-1:0] ratio);
    return 6'(ratio) + 6'h01;
  endfunction

endpackage

// File: src/pgs_top.sv
// divider go sequencer of two clock controllers with a plain register port
// assumes reference ticks and the register port come from logic on clk_sys
// Functional notes
// - the go-in-progress flag gives no indication of a running divider change and reads as zero.
// - only the fourth and fifth dividers of controller one and the first of controller two are programmable.
// - writing a ratio that differs from the current one sets that divider's changed flag.
// - writing one to the go trigger bit starts applying pending ratios to flagged dividers.
// - divided clocks being changed pause briefly while unchanged ones keep running.
// - with the locked path selected, controller one's reference is the multiplied loop output.
// - with bypass selected, controller one's reference is the primary input clock.
// - clocks of affected dividers may stop during a change and their logic must tolerate it.
// - controller two is always locked, its reference being ten times the secondary input clock.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pgs_top
  import pgs_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              pll1Tick,
  input  wire logic              primaryTick,
  input  wire logic              pll2Tick,
  output logic                   divTick4,
  output logic                   divTick5,
  output logic                   divTick21,
  output logic                   irq
);

  logic               lockedPathSelect;
  logic [RATIO_W-1:0] pend4;
  logic [RATIO_W-1:0] pend5;
  logic [RATIO_W-1:0] pend21;
  logic [2:0]         dchg;
  logic [1:0]         istat;
  logic [1:0]         imask;
  logic               applied1;
  logic               applied2;
  logic               next_lockedPathSelect;
  logic [RATIO_W-1:0] next_pend4;
  logic [RATIO_W-1:0] next_pend5;
  logic [RATIO_W-1:0] next_pend21;
  logic [2:0]         next_dchg;
  logic [1:0]         next_istat;
  logic [1:0]         next_imask;
  logic               next_applied1;
  logic               next_applied2;
  logic [31:0]        next_rdata;

  logic               ref1;
  logic               ref2;
  logic [RATIO_W-1:0] cur4;
  logic [RATIO_W-1:0] cur5;
  logic [RATIO_W-1:0] cur21;
  logic               busy1;
  logic               busy2;
  logic               apply1;
  logic               apply2;
  logic               done1;
  logic               done2;
  logic               goStart1;
  logic               goStart2;
  logic               goInProgressFlag;
  logic [WAIT_W-1:0]  lcmAt1;
  logic [WAIT_W-1:0]  lcmAt2;
  logic [WAIT_W-1:0]  wait1;
  logic [WAIT_W-1:0]  wait2;
  logic               wrCtrl;
  logic               wrCmd;
  logic               wrDiv4;
  logic               wrDiv5;
  logic               wrDiv21;
  logic               wrIstat;
  logic               wrImask;

  // reference selection follows the path bit live; switching it mid-change stretches the wait
  assign ref1 = lockedPathSelect ? pll1Tick : primaryTick;
  // controller two has no bypass, its reference is always the multiplied secondary clock
  assign ref2 = pll2Tick;

  // the status flag is deliberately not wired to the sequencer
  assign goInProgressFlag = 1'b0;

  assign wrCtrl  = wr && (addr == OFS_CTRL);
  assign wrCmd   = wr && (addr == OFS_CMD);
  assign wrDiv4  = wr && (addr == OFS_DIV4);
  assign wrDiv5  = wr && (addr == OFS_DIV5);
  assign wrDiv21 = wr && (addr == OFS_DIV21);
  assign wrIstat = wr && (addr == OFS_ISTAT);
  assign wrImask = wr && (addr == OFS_IMASK);

  assign goStart1 = wrCmd && wdata[BIT_GO1] && !busy1;
  assign goStart2 = wrCmd && wdata[BIT_GO2] && !busy2;

  // wait computed from the old divide values, captured by the timer at the go write
  assign lcmAt1 = 12'(pgs_lcm(pgs_divval(cur4), pgs_divval(cur5))) * GO_LCM_MULT;
  // a single programmable divider is its own least common multiple
  assign lcmAt2 = 12'(pgs_divval(cur21)) * GO_LCM_MULT;
  assign wait1  = lcmAt1 + GO_OVERHEAD;
  assign wait2  = lcmAt2 + GO_OVERHEAD;

  assign irq = |(istat & imask);

  always_comb begin
    next_lockedPathSelect = lockedPathSelect;
    next_pend4            = pend4;
    next_pend5            = pend5;
    next_pend21           = pend21;
    next_dchg             = dchg;
    next_istat            = istat;
    next_imask            = imask;
    next_applied1         = applied1;
    next_applied2         = applied2;
    if (wrCtrl) begin
      next_lockedPathSelect = wdata[BIT_LOCKED];
    end
    if (wrImask) begin
      next_imask = wdata[1:0];
    end
    if (goStart1) begin
      next_applied1 = 1'b0;
    end else if (apply1) begin
      next_applied1 = 1'b1;
    end
    if (goStart2) begin
      next_applied2 = 1'b0;
    end else if (apply2) begin
      next_applied2 = 1'b1;
    end
    // a finished go clears its flags; a ratio write in the same cycle still wins
    if (done1) begin
      next_dchg[BIT_CHG4] = 1'b0;
      next_dchg[BIT_CHG5] = 1'b0;
    end
    if (done2) begin
      next_dchg[BIT_CHG21] = 1'b0;
    end
    if (wrDiv4) begin
      next_pend4 = wdata[RATIO_W-1:0];
      if (wdata[RATIO_W-1:0] != cur4) begin
        next_dchg[BIT_CHG4] = 1'b1;
      end
    end
    if (wrDiv5) begin
      next_pend5 = wdata[RATIO_W-1:0];
      if (wdata[RATIO_W-1:0] != cur5) begin
        next_dchg[BIT_CHG5] = 1'b1;
      end
    end
    if (wrDiv21) begin
      next_pend21 = wdata[RATIO_W-1:0];
      if (wdata[RATIO_W-1:0] != cur21) begin
        next_dchg[BIT_CHG21] = 1'b1;
      end
    end
    // write one to clear, a completion in the same cycle stays set
    if (wrIstat) begin
      next_istat = istat & ~wdata[1:0];
    end
    if (done1) begin
      next_istat[BIT_GO1] = 1'b1;
    end
    if (done2) begin
      next_istat[BIT_GO2] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        OFS_CTRL:  next_rdata[BIT_LOCKED] = lockedPathSelect;
        OFS_STAT: begin
          next_rdata[BIT_GO1]   = goInProgressFlag;
          next_rdata[BIT_GO2]   = goInProgressFlag;
          next_rdata[BIT_BUSY1] = busy1;
          next_rdata[BIT_BUSY2] = busy2;
        end
        OFS_DIV4:  next_rdata[RATIO_W-1:0] = pend4;
        OFS_DIV5:  next_rdata[RATIO_W-1:0] = pend5;
        OFS_DIV21: next_rdata[RATIO_W-1:0] = pend21;
        OFS_DCHG:  next_rdata[2:0] = dchg;
        OFS_ISTAT: next_rdata[1:0] = istat;
        OFS_IMASK: next_rdata[1:0] = imask;
        default:   next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockedPathSelect <= RST_LOCKED;
      pend4            <= RST_RATIO4;
      pend5            <= RST_RATIO5;
      pend21           <= RST_RATIO21;
      dchg             <= 3'h0;
      istat            <= 2'h0;
      imask            <= RST_IMASK;
      applied1         <= 1'b0;
      applied2         <= 1'b0;
      rdata            <= 32'h0000_0000;
    end else if (ce) begin
      lockedPathSelect <= next_lockedPathSelect;
      pend4            <= next_pend4;
      pend5            <= next_pend5;
      pend21           <= next_pend21;
      dchg             <= next_dchg;
      istat            <= next_istat;
      imask            <= next_imask;
      applied1         <= next_applied1;
      applied2         <= next_applied2;
      rdata            <= next_rdata;
    end
  end

  pgs_go_timer u_timer1 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .start   (goStart1),
    .refTick (ref1),
    .nCycles (wait1),
    .applyAt (lcmAt1),
    .busy    (busy1),
    .apply   (apply1),
    .done    (done1)
  );

  pgs_go_timer u_timer2 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .start   (goStart2),
    .refTick (ref2),
    .nCycles (wait2),
    .applyAt (lcmAt2),
    .busy    (busy2),
    .apply   (apply2),
    .done    (done2)
  );

  // only flagged dividers pause, from the go until the new ratio is loaded
  pgs_clk_div #(.RST_RATIO(RST_RATIO4)) u_div4 (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .refTick  (ref1),
    .pause    (busy1 && dchg[BIT_CHG4] && !applied1),
    .load     (apply1 && dchg[BIT_CHG4]),
    .newRatio (pend4),
    .curRatio (cur4),
    .divTick  (divTick4)
  );

  pgs_clk_div #(.RST_RATIO(RST_RATIO5)) u_div5 (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .refTick  (ref1),
    .pause    (busy1 && dchg[BIT_CHG5] && !applied1),
    .load     (apply1 && dchg[BIT_CHG5]),
    .newRatio (pend5),
    .curRatio (cur5),
    .divTick  (divTick5)
  );

  pgs_clk_div #(.RST_RATIO(RST_RATIO21)) u_div21 (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .refTick  (ref2),
    .pause    (busy2 && dchg[BIT_CHG21] && !applied2),
    .load     (apply2 && dchg[BIT_CHG21]),
    .newRatio (pend21),
    .curRatio (cur21),
    .divTick  (divTick21)
  );

  a_status_flag_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(rd) && $past(addr) == OFS_STAT) |-> (rdata[1:0] == 2'h0))
    else $error("go-in-progress flag read as set");

  a_flags_three_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(rd) && $past(addr) == OFS_DCHG) |-> (rdata[31:3] == 29'h0000_0000))
    else $error("changed flags beyond the three dividers");

  a_changed_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && wrDiv4 && wdata[RATIO_W-1:0] != cur4) |=> dchg[BIT_CHG4])
    else $error("ratio change not flagged");

  a_go_starts: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && goStart1) |=> busy1 ##0 !applied1)
    else $error("go write did not start the change");

  a_ref_locked: assert property (@(posedge clk_sys) disable iff (!nrst)
    lockedPathSelect |-> (ref1 == pll1Tick))
    else $error("locked mode reference not the loop output");

  a_ref_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
    !lockedPathSelect |-> (ref1 == primaryTick))
    else $error("bypass reference not the primary input");

  a_unchanged_runs: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && busy1 && !dchg[BIT_CHG5] && ref1 && cur5 == 5'h00) |=> divTick5)
    else $error("unchanged divider stalled during go");

  a_new_ratio_loaded: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && done1 && $past(dchg[BIT_CHG4])) |-> (cur4 == pend4 || $past(wrDiv4, 2)))
    else $error("flagged divider missed its new ratio");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq == |(istat & imask))
    else $error("interrupt output disagrees with status and mask");

endmodule // pgs_top
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the divider go sequencer: register port, go timing, pauses, interrupt
// assumes pgs_top alone on clk_sys, reference ticks driven here as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pgs_pkg::*;
;
  logic              clk_sys;
  logic              nrst;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  logic              pll1Tick;
  logic              primaryTick;
  logic              pll2Tick;
  logic              divTick4;
  logic              divTick5;
  logic              divTick21;
  logic              irq;
  int                err_count;
  int                n_checks;
  int                cnt4;
  int                cnt5;
  int                cnt21;

  pgs_top DUT (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .ce          (ce),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .pll1Tick    (pll1Tick),
    .primaryTick (primaryTick),
    .pll2Tick    (pll2Tick),
    .divTick4    (divTick4),
    .divTick5    (divTick5),
    .divTick21   (divTick21),
    .irq         (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // divided clock enables are counted here so scenarios can judge pauses and rates
  always @(posedge clk_sys) begin
    if (divTick4 === 1'b1) cnt4++;
    if (divTick5 === 1'b1) cnt5++;
    if (divTick21 === 1'b1) cnt21++;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so they are taken there
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  // one-cycle reference pulses with a one-cycle gap; 0 locked loop, 1 primary input, 2 controller two
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      case (sel)
        0: pll1Tick <= 1'b1;
        1: primaryTick <= 1'b1;
        default: pll2Tick <= 1'b1;
      endcase
      @(posedge clk_sys);
      {pll1Tick, primaryTick, pll2Tick} <= 3'b000;
    end
  endtask

  function automatic int lcm(input int a, input int b);
    int m;
    m = a;
    while (m % b != 0) m += a;
    return m;
  endfunction

  task automatic t_reset_values();
    logic [ADDR_W-1:0] a [9];
    logic [31:0]       e [9];
    a = '{OFS_CTRL, OFS_STAT, OFS_CMD, OFS_DIV4, OFS_DIV5, OFS_DIV21, OFS_DCHG, OFS_ISTAT, OFS_IMASK};
    e = '{32'(RST_LOCKED), 32'h0, 32'h0, 32'(RST_RATIO4), 32'(RST_RATIO5), 32'(RST_RATIO21), 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      rd_chk(a[i], e[i], "reset value");
    end
    wr_reg(8'h24, 32'hFFFFFFFF);
    rd_chk(8'h24, 32'h0, "unmapped place");
  endtask

  task automatic t_change_flags();
    rd_chk(OFS_STAT, 32'h0, "no go in progress before programming");
    wr_reg(OFS_DIV5, 32'h3);
    rd_chk(OFS_DCHG, 32'h0, "same ratio leaves flag clear");
    wr_reg(OFS_DIV4, 32'h4);
    rd_chk(OFS_DCHG, 32'h1, "changed ratio flags divider");
    rd_chk(OFS_DIV4, 32'h4, "pending ratio readback");
  endtask

  // old divides 4 and 4 in bypass: N = 2*4+50 primary ticks
  task automatic t_go_bypass();
    int n;
    n = 2 * lcm(4, 4) + 50;
    wr_reg(OFS_IMASK, 32'h1);
    wr_reg(OFS_CMD, 32'h1);
    rd_chk(OFS_STAT, 32'h100, "busy set, go flag stays zero");
    cnt4 = 0;
    cnt5 = 0;
    pulse(0, 10);
    chk(32'(cnt5), 32'h0, "loop ticks ignored in bypass");
    pulse(1, 7);
    chk(32'(cnt4), 32'h0, "changed divider paused");
    chk(32'(cnt5 >= 1), 32'h1, "unchanged divider keeps ticking");
    wr_reg(OFS_CMD, 32'h1);
    pulse(1, 1);
    repeat (2) @(posedge clk_sys);
    cnt4 = 0;
    pulse(1, n - 9);
    chk(32'(cnt4 >= 9 && cnt4 <= 10), 32'h1, "new divide by five rate");
    rd_chk(OFS_STAT, 32'h100, "still busy one tick before end");
    chk(32'(irq), 32'h0, "no interrupt before done");
    pulse(1, 1);
    repeat (2) @(posedge clk_sys);
    rd_chk(OFS_STAT, 32'h0, "idle after N ticks");
    rd_chk(OFS_ISTAT, 32'h1, "done event");
    rd_chk(OFS_DCHG, 32'h0, "flags cleared at done");
    rd_chk(OFS_DIV4, 32'h4, "ratio applied");
  endtask

  task automatic t_irq();
    chk(32'(irq), 32'h1, "unmasked done raises irq");
    wr_reg(OFS_IMASK, 32'h0);
    #1;
    chk(32'(irq), 32'h0, "masked done hides irq");
    wr_reg(OFS_IMASK, 32'h1);
    #1;
    chk(32'(irq), 32'h1, "unmask shows irq again");
    wr_reg(OFS_ISTAT, 32'h1);
    #1;
    chk(32'(irq), 32'h0, "write one clears event");
    rd_chk(OFS_ISTAT, 32'h0, "event cleared");
  endtask

  // controller two: single old divide 2, N = 2*2+50 ticks of its own reference
  task automatic t_go_ctrl2();
    int n;
    n = 2 * lcm(2, 2) + 50;
    wr_reg(OFS_DIV21, 32'h4);
    rd_chk(OFS_DCHG, 32'h4, "controller two flag");
    wr_reg(OFS_CMD, 32'h2);
    cnt21 = 0;
    pulse(1, 20);
    rd_chk(OFS_STAT, 32'h200, "controller two ignores primary ticks");
    pulse(2, 3);
    chk(32'(cnt21), 32'h0, "controller two divider paused");
    pulse(2, n - 4);
    rd_chk(OFS_STAT, 32'h200, "controller two busy before end");
    pulse(2, 1);
    repeat (2) @(posedge clk_sys);
    rd_chk(OFS_STAT, 32'h0, "controller two idle");
    rd_chk(OFS_ISTAT, 32'h2, "controller two done");
    // load lands before the fifth tick, so fifty ticks at divide by five remain
    chk(32'(cnt21), 32'h0000_000A, "controller two new divide by five rate");
    chk(32'(irq), 32'h0, "masked event keeps irq low");
  endtask

  // locked path: old divides 5 and 4, N = 2*20+50 loop ticks
  task automatic t_go_locked();
    int n;
    n = 2 * lcm(5, 4) + 50;
    wr_reg(OFS_CTRL, 32'h1);
    rd_chk(OFS_CTRL, 32'h1, "locked path selected");
    wr_reg(OFS_DIV5, 32'h1);
    wr_reg(OFS_CMD, 32'h1);
    pulse(1, 100);
    rd_chk(OFS_STAT, 32'h100, "primary ticks ignored when locked");
    pulse(0, n - 1);
    rd_chk(OFS_STAT, 32'h100, "busy one tick before end");
    pulse(0, 1);
    repeat (2) @(posedge clk_sys);
    rd_chk(OFS_STAT, 32'h0, "idle after N loop ticks");
    rd_chk(OFS_ISTAT, 32'h3, "both done events");
    chk(32'(irq), 32'h1, "done of controller one raises irq");
  endtask

  // a frozen block ignores the port, so the old mask must survive the write
  task automatic t_ce_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    wr_reg(OFS_IMASK, 32'h0);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk(OFS_IMASK, 32'h1, "mask write ignored while frozen");
    chk(32'(irq), 32'h1, "irq kept while frozen");
  endtask

  initial begin
    #120000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    err_count   = 0;
    n_checks    = 0;
    cnt4        = 0;
    cnt5        = 0;
    cnt21       = 0;
    nrst        = 1'b0;
    ce          = 1'b1;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    pll1Tick    = 1'b0;
    primaryTick = 1'b0;
    pll2Tick    = 1'b0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset_values();
    t_change_flags();
    t_go_bypass();
    t_irq();
    t_go_ctrl2();
    t_go_locked();
    t_ce_freeze();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
